/* File: design/tw_pkg.sv */
`default_nettype none
package tw_pkg;
    // counting family selected by the waveform mode
    typedef enum logic [2:0] {
        TW_NORMAL   = 3'h0,
        TW_CLRMATCH = 3'h1,
        TW_FAST     = 3'h3,
        TW_PC       = 3'h2,
        TW_PFC      = 3'h6,
        TW_RSV      = 3'h7
    } tw_kind_t;
    // tick source select encoding
    typedef enum logic [2:0] {
        TW_CS_STOP = 3'h0, TW_CS_DIV1 = 3'h1, TW_CS_DIV8 = 3'h2, TW_CS_DIV64 = 3'h3,
        TW_CS_DIV256 = 3'h4, TW_CS_DIV1024 = 3'h5, TW_CS_EXTF = 3'h6, TW_CS_EXTR = 3'h7
    } tw_tick_sel_t;
    // per channel output mode
    typedef enum logic [1:0] {
        TW_COM_OFF = 2'h0, TW_COM_TOG = 2'h1, TW_COM_CLR = 2'h2, TW_COM_SET = 2'h3
    } tw_com_t;
endpackage
`default_nettype wire

/* File: design/tw_regs.svh */
`ifndef TW_REGS_SVH
`define TW_REGS_SVH
// ************************************************************
// register byte addresses on the apb bus
// ************************************************************
`define TW_ADDR_CTRLA 12'h080
`define TW_ADDR_CTRLB 12'h084
`define TW_ADDR_CMPA  12'h088
`define TW_ADDR_CMPB  12'h08C
`define TW_ADDR_CAPT  12'h090
`define TW_ADDR_CNT   12'h094
`define TW_ADDR_STAT  12'h098
`define TW_ADDR_MASK  12'h09C
// ************************************************************
// field positions and reset values
// ************************************************************
`define TW_COMA_HI    7
`define TW_COMB_HI    5
`define TW_WGML_HI    1
`define TW_WGMH_HI    4
`define TW_CS_HI      2
`define TW_CTRLA_WMASK 8'hF3
`define TW_RST8       8'h00
`define TW_RST16      16'h0000
`define TW_ST_OVF     0
`define TW_ST_MTA     1
`define TW_ST_MTB     2
// ************************************************************
// counter limits and prescaler taps
// ************************************************************
`define TW_BOTTOM     16'h0000
`define TW_MAX        16'hFFFF
`define TW_TOP8       16'h00FF
`define TW_TOP9       16'h01FF
`define TW_TOP10      16'h03FF
`define TW_ONE16      16'h0001
`define TW_PS_ONE     10'h001
`define TW_PS_DIV8    10'h007
`define TW_PS_DIV64   10'h03F
`define TW_PS_DIV256  10'h0FF
`define TW_PS_DIV1024 10'h3FF
`endif

/* File: design/tw_waveform_ctrl.sv */
// Register access over APB was left to the implementer.
`include "tw_regs.svh"
`default_nettype none
// Operation
// - everything runs on sys_clk; the timer tick is a one-cycle enable
// - phase and frequency correct mode loads compare values from buffers at BOTTOM
// - control A: chan A mode 7:6, chan B mode 5:4, mode low 1:0, 3:2 zero
// - a nonzero channel output mode hands the pin to the compare output, except toggle where it is not supported and any mode in mode 13
// - non-PWM modes: 00 off, 01 toggle, 10 clear, 11 set on match
// - fast PWM toggle mode works on channel A only in modes 14 and 15
// - fast PWM: 10 clears on match sets at BOTTOM, 11 the inverse
// - fast PWM: match at TOP ignored with upper mode bit, BOTTOM action kept
// - dual-slope toggle mode works on channel A only in modes 9 and 11
// - dual-slope: 10 clears on up-count match, sets on down-count match; 11 inverse
// - four-bit waveform mode from control A low bits and control B high bits
// - modes 0, 4, 12: TOP max, compare A, capture; immediate update, flag at MAX
// - modes 1 to 3: phase correct fixed TOP, update at TOP, flag at BOTTOM
// - fast PWM modes update at TOP and raise overflow at TOP, on the same tick
// - modes 8 to 11: dual slope, TOP from capture or compare A
// - tick from stop, divide by 1, 8, 64, 256, 1024 or pin edge
module tw_waveform_ctrl (
    // clock and reset
    input  wire logic        sys_clk,
    input  wire logic        sys_rst,
    // apb slave
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [11:0] paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    // external tick pin
    input  wire logic        extTickPin,
    // compare outputs towards the port pins
    output logic             compareOutA,
    output logic             compareOutB,
    output logic             compareEnA,
    output logic             compareEnB,
    // interrupt
    output logic             irq
);
    import tw_pkg::*;

    // ************************************************************
    // declarations
    // ************************************************************
    logic [7:0]   ctrlA_q;
    logic [4:0]   ctrlB_q;
    logic [15:0]  capture_q;
    logic [15:0]  count_q;
    logic         countUp_q;
    logic         blockMatch_q;
    logic [2:0]   status_q;
    logic [2:0]   mask_q;
    logic [9:0]   presc_q;
    logic [2:0]   pinSync_q;
    logic         pinStable_q;
    logic [31:0]  prdata_q;
    logic         pready_q;
    logic         pslverr_q;
    logic         irq_q;
    logic [3:0]   waveMode;
    tw_kind_t     kind;
    tw_tick_sel_t tickSel;
    logic [15:0]  topVal;
    logic [15:0]  fixedTop;
    logic         dual;
    logic         fast;
    logic         nonPwm;
    logic         immediate;
    logic         atTop;
    logic         atBottom;
    logic         tick;
    logic         pinRise;
    logic         pinFall;
    logic         updEv;
    logic         ovfEv;
    logic [1:0]   matchSet;
    logic         apbSetup;
    logic         apbWrite;
    logic         apbRead;
    logic         mapped;
    logic [31:0]  rdMux;
    logic [2:0]   clrBits;

    // ************************************************************
    // mode decode
    // ************************************************************
    // mode bits are split across the two control registers
    assign waveMode = {ctrlB_q[`TW_WGMH_HI -: 2], ctrlA_q[`TW_WGML_HI -: 2]};
    assign tickSel  = tw_tick_sel_t'(ctrlB_q[`TW_CS_HI -: 3]);

    // fixed tops share the low two mode bits in both fixed families
    always_comb begin
        unique case (waveMode[1:0])
            2'h1:    fixedTop = `TW_TOP8;
            2'h2:    fixedTop = `TW_TOP9;
            2'h3:    fixedTop = `TW_TOP10;
            default: fixedTop = `TW_MAX;
        endcase
    end

    // family and top source; compare A as top is the active, buffered copy
    always_comb begin
        unique case (waveMode)
            4'h0:                   begin kind = TW_NORMAL; topVal = `TW_MAX;    end
            4'h1, 4'h2, 4'h3:       begin kind = TW_PC;     topVal = fixedTop;   end
            4'h4:                   begin kind = TW_CLRMATCH; topVal = chan[0].cmp_q; end
            4'h5, 4'h6, 4'h7:       begin kind = TW_FAST;   topVal = fixedTop;   end
            4'h8:                   begin kind = TW_PFC;    topVal = capture_q;  end
            4'h9:                   begin kind = TW_PFC;    topVal = chan[0].cmp_q; end
            4'hA:                   begin kind = TW_PC;     topVal = capture_q;  end
            4'hB:                   begin kind = TW_PC;     topVal = chan[0].cmp_q; end
            4'hC:                   begin kind = TW_CLRMATCH; topVal = capture_q;  end
            4'hD:                   begin kind = TW_RSV;    topVal = `TW_MAX;    end
            4'hE:                   begin kind = TW_FAST;   topVal = capture_q;  end
            4'hF:                   begin kind = TW_FAST;   topVal = chan[0].cmp_q; end
        endcase
    end

    assign dual      = (kind == TW_PC) || (kind == TW_PFC);
    assign fast      = (kind == TW_FAST);
    assign nonPwm    = (kind == TW_NORMAL) || (kind == TW_CLRMATCH);
    assign immediate = nonPwm || (kind == TW_RSV);
    assign atTop     = (count_q == topVal);
    assign atBottom  = (count_q == `TW_BOTTOM);

    // ************************************************************
    // tick generation
    // ************************************************************
    // prescaler runs only while a source is chosen, so ticks restart in phase
    always_ff @(posedge sys_clk) begin
        if (sys_rst || tickSel == TW_CS_STOP) begin
            presc_q <= 10'h000;
        end else begin
            presc_q <= presc_q + `TW_PS_ONE;
        end
    end

    // pin sampler: the first stage feeds only the second
    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            pinSync_q   <= 3'h0;
            pinStable_q <= 1'b0;
        end else begin
            pinSync_q <= {pinSync_q[1:0], extTickPin};
            if (pinSync_q[1] == pinSync_q[2]) begin
                pinStable_q <= pinSync_q[2];
            end
        end
    end

    assign pinRise = (pinSync_q[1] == pinSync_q[2]) && pinSync_q[2] && !pinStable_q;
    assign pinFall = (pinSync_q[1] == pinSync_q[2]) && !pinSync_q[2] && pinStable_q;

    // tick is a clock enable, never a clock
    always_comb begin
        unique case (tickSel)
            TW_CS_STOP:    tick = 1'b0;
            TW_CS_DIV1:    tick = 1'b1;
            TW_CS_DIV8:    tick = (presc_q & `TW_PS_DIV8) == `TW_PS_DIV8;
            TW_CS_DIV64:   tick = (presc_q & `TW_PS_DIV64) == `TW_PS_DIV64;
            TW_CS_DIV256:  tick = (presc_q & `TW_PS_DIV256) == `TW_PS_DIV256;
            TW_CS_DIV1024: tick = presc_q == `TW_PS_DIV1024;
            TW_CS_EXTF:    tick = pinFall;
            TW_CS_EXTR:    tick = pinRise;
        endcase
    end

    // ************************************************************
    // counter
    // ************************************************************
    // dual slope turns at TOP and BOTTOM; single slope wraps to BOTTOM at TOP
    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            count_q   <= `TW_RST16;
            countUp_q <= 1'b1;
        end else if (apbWrite && paddr == `TW_ADDR_CNT) begin
            count_q <= pwdata[15:0];
        end else if (tick) begin
            if (!dual) begin
                countUp_q <= 1'b1;
                count_q   <= atTop ? `TW_BOTTOM : count_q + `TW_ONE16;
            end else if (countUp_q) begin
                countUp_q <= !atTop;
                count_q   <= atTop ? count_q - `TW_ONE16 : count_q + `TW_ONE16;
            end else begin
                countUp_q <= atBottom;
                count_q   <= atBottom ? count_q + `TW_ONE16 : count_q - `TW_ONE16;
            end
        end
    end

    // a software write to the counter hides the match on the next tick
    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            blockMatch_q <= 1'b0;
        end else if (apbWrite && paddr == `TW_ADDR_CNT) begin
            blockMatch_q <= 1'b1;
        end else if (tick) begin
            blockMatch_q <= 1'b0;
        end
    end

    // buffer load point and overflow point per family
    always_comb begin
        updEv = 1'b0;
        ovfEv = 1'b0;
        if (tick) begin
            unique case (kind)
                TW_PC: begin
                    updEv = atTop && countUp_q;
                    ovfEv = atBottom && !countUp_q;
                end
                TW_PFC: begin
                    updEv = atBottom && !countUp_q;
                    ovfEv = atBottom && !countUp_q;
                end
                TW_FAST: begin
                    updEv = atTop;
                    ovfEv = atTop;
                end
                TW_NORMAL, TW_CLRMATCH, TW_RSV: begin
                    ovfEv = (count_q == `TW_MAX);
                end
            endcase
        end
    end

    // ************************************************************
    // compare channels
    // ************************************************************
    for (genvar i = 0; i < 2; i++) begin : chan
        localparam int          HI   = (i == 0) ? `TW_COMA_HI : `TW_COMB_HI;
        localparam logic [11:0] ADDR = (i == 0) ? `TW_ADDR_CMPA : `TW_ADDR_CMPB;
        tw_com_t     com;
        logic [15:0] buf_q;
        logic [15:0] cmp_q;
        logic        pend_q;
        logic        dirUp_q;
        logic        oc_q;
        logic        en_q;
        logic        apply;
        logic        ignore;
        logic        togOk;

        assign com    = tw_com_t'(ctrlA_q[HI -: 2]);
        // toggle in pwm families exists only on channel A, in modes 9, 11, 14 and 15
        assign togOk  = (i == 0) && ((fast && waveMode[3:1] == 3'h7)
                        || (dual && waveMode[3] && waveMode[0]));
        assign apply  = tick && pend_q;
        assign ignore = fast && com[1] && (cmp_q == topVal);

        // software writes always land in the buffer
        always_ff @(posedge sys_clk) begin
            if (sys_rst) begin
                buf_q <= `TW_RST16;
            end else if (apbWrite && paddr == ADDR) begin
                buf_q <= pwdata[15:0];
            end
        end

        // active copy follows the buffer at the family's update point
        always_ff @(posedge sys_clk) begin
            if (sys_rst) begin
                cmp_q <= `TW_RST16;
            end else if (immediate || updEv) begin
                cmp_q <= buf_q;
            end
        end

        // equality seen on one tick is acted on at the next tick
        always_ff @(posedge sys_clk) begin
            if (sys_rst) begin
                pend_q  <= 1'b0;
                dirUp_q <= 1'b0;
            end else if (tick) begin
                pend_q  <= (count_q == cmp_q) && !blockMatch_q;
                dirUp_q <= countUp_q;
            end
        end

        // waveform register; in fast pwm the BOTTOM action is written last so it wins
        always_ff @(posedge sys_clk) begin
            if (sys_rst) begin
                oc_q <= 1'b0;
            end else if (com == TW_COM_TOG) begin
                if (apply && (nonPwm || togOk)) begin
                    oc_q <= !oc_q;
                end
            end else if (com[1]) begin
                if (nonPwm) begin
                    if (apply) begin
                        oc_q <= com[0];
                    end
                end else if (fast) begin
                    if (apply && !ignore) begin
                        oc_q <= com[0];
                    end
                    if (tick && atTop) begin
                        oc_q <= !com[0];
                    end
                end else if (dual && apply) begin
                    oc_q <= dirUp_q ? com[0] : !com[0];
                end
            end
        end

        // pin takeover; the pin driver itself also needs its direction bit
        always_ff @(posedge sys_clk) begin
            if (sys_rst) begin
                en_q <= 1'b0;
            end else begin
                en_q <= (com != TW_COM_OFF) && (nonPwm || togOk
                        || (com[1] && kind != TW_RSV));
            end
        end
    end

    assign matchSet    = {chan[1].apply, chan[0].apply};
    assign compareOutA = chan[0].oc_q;
    assign compareOutB = chan[1].oc_q;
    assign compareEnA  = chan[0].en_q;
    assign compareEnB  = chan[1].en_q;

    // ************************************************************
    // apb slave
    // ************************************************************
    assign apbSetup = psel && !penable;
    assign apbWrite = psel && penable && pready_q && pwrite;
    assign apbRead  = psel && penable && pready_q && !pwrite;

    // read data is captured in the setup cycle so the port comes from a flop
    always_comb begin
        rdMux  = 32'h0000_0000;
        mapped = 1'b1;
        unique case (paddr)
            `TW_ADDR_CTRLA: rdMux[7:0]  = ctrlA_q;
            `TW_ADDR_CTRLB: rdMux[4:0]  = ctrlB_q;
            `TW_ADDR_CMPA:  rdMux[15:0] = chan[0].cmp_q;
            `TW_ADDR_CMPB:  rdMux[15:0] = chan[1].cmp_q;
            `TW_ADDR_CAPT:  rdMux[15:0] = capture_q;
            `TW_ADDR_CNT:   rdMux[15:0] = count_q;
            `TW_ADDR_STAT:  rdMux[2:0]  = status_q;
            `TW_ADDR_MASK:  rdMux[2:0]  = mask_q;
            default:        mapped      = 1'b0;
        endcase
    end

    // one wait-free access phase: pready rises the cycle after setup
    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            pready_q  <= 1'b0;
            pslverr_q <= 1'b0;
            prdata_q  <= 32'h0000_0000;
        end else begin
            pready_q <= apbSetup;
            if (apbSetup) begin
                pslverr_q <= !mapped;
                prdata_q  <= pwrite ? 32'h0000_0000 : rdMux;
            end
        end
    end

    // control and capture registers; bits 3:2 of control A stay zero
    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            ctrlA_q   <= `TW_RST8;
            ctrlB_q   <= 5'h00;
            capture_q <= `TW_RST16;
            mask_q    <= 3'h0;
        end else if (apbWrite) begin
            if (paddr == `TW_ADDR_CTRLA) ctrlA_q <= pwdata[7:0] & `TW_CTRLA_WMASK;
            if (paddr == `TW_ADDR_CTRLB) ctrlB_q <= pwdata[4:0];
            if (paddr == `TW_ADDR_CAPT) capture_q <= pwdata[15:0];
            if (paddr == `TW_ADDR_MASK) mask_q <= pwdata[2:0];
        end
    end

    // ************************************************************
    // status and interrupt
    // ************************************************************
    // only bits that were actually returned are cleared, and a new set wins
    assign clrBits = (apbRead && paddr == `TW_ADDR_STAT) ? prdata_q[2:0] : 3'h0;

    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            status_q <= 3'h0;
        end else begin
            status_q <= (status_q & ~clrBits) | {matchSet, ovfEv};
        end
    end

    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            irq_q <= 1'b0;
        end else begin
            irq_q <= |(status_q & mask_q);
        end
    end

    assign prdata  = prdata_q;
    assign pready  = pready_q;
    assign pslverr = pslverr_q;
    assign irq     = irq_q;

    // ************************************************************
    // checks
    // ************************************************************
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (sys_rst);

    sequence eqSeenA;
        tick && count_q == chan[0].cmp_q && !blockMatch_q;
    endsequence
    sequence nextTickA;
        chan[0].pend_q && tick;
    endsequence

    tick_div8_a: assert property ((tickSel == TW_CS_DIV8 && tick)
        |=> (!tick || tickSel != TW_CS_DIV8) [*7])
        else $error("divide by 8 tick came too early");
    pfc_update_a: assert property ((kind == TW_PFC && updEv)
        |=> chan[0].cmp_q == $past(chan[0].buf_q))
        else $error("compare A not loaded at BOTTOM");
    ctrl_rsvd_a: assert property (ctrlA_q[3:2] == 2'h0)
        else $error("reserved control bits nonzero");
    pin_takeover_a: assert property ((nonPwm && ctrlA_q[7:6] != 2'h0) |=> compareEnA)
        else $error("channel A did not take the pin");
    match_toggle_a: assert property ((nonPwm && chan[0].com == TW_COM_TOG && chan[0].apply)
        |=> compareOutA != $past(compareOutA))
        else $error("channel A did not toggle on match");
    fast_bottom_a: assert property ((fast && chan[1].com == TW_COM_CLR && tick && atTop)
        |=> compareOutB)
        else $error("channel B not set at BOTTOM");
    top_ignore_a: assert property ((chan[0].apply && chan[0].ignore && !(tick && atTop))
        |=> $stable(compareOutA))
        else $error("match at TOP was not ignored");
    dual_up_a: assert property ((dual && chan[0].com == TW_COM_CLR
        && chan[0].apply && chan[0].dirUp_q) |=> !compareOutA)
        else $error("up-count match did not clear");
    pc_ovf_a: assert property ((kind == TW_PC && tick && atBottom && !countUp_q)
        |=> status_q[`TW_ST_OVF])
        else $error("overflow flag missing at BOTTOM");
    // the match is split in two steps so no unbounded wait between ticks is needed
    match_pend_a: assert property (eqSeenA |=> chan[0].pend_q)
        else $error("compare A equality not noted");
    match_flag_a: assert property (nextTickA |=> status_q[`TW_ST_MTA])
        else $error("compare A flag missing");
endmodule
`default_nettype wire

/* File: verif/timer16_waveform_output_control_test.sv */
`include "tw_regs.svh"
`default_nettype none
module timer16_waveform_output_control_test;
    timeunit 1ns;
    timeprecision 1ps;
    // ****
    // bench signals
    // ****
    logic        sys_clk, sys_rst, psel, penable, pwrite, extTickPin, dirA, dirB;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata;
    logic        pready, pslverr, compareOutA, compareOutB, compareEnA, compareEnB, irq;
    logic        pinA, pinB;
    logic [32:0] readNotes[$];
    logic [15:0] c1;
    int          miscompares, checked, seed, h1, h2;
    tw_waveform_ctrl dut (.sys_clk, .sys_rst, .psel, .penable, .pwrite, .paddr, .pwdata,
        .prdata, .pready, .pslverr, .extTickPin, .compareOutA, .compareOutB, .compareEnA,
        .compareEnB, .irq);
    tw_pin_model pa (.compareOut(compareOutA), .compareEn(compareEnA), .dirOut(dirA),
        .portData(1'b0), .pinLevel(pinA));
    tw_pin_model pb (.compareOut(compareOutB), .compareEn(compareEnB), .dirOut(dirB),
        .portData(1'b0), .pinLevel(pinB));
    initial begin
        sys_clk = 1'b0;
        forever #20 sys_clk = ~sys_clk;
    end
    // ****
    // comparison and bus tasks
    // ****
    task automatic chk(input logic [32:0] got, input logic [32:0] exp);
        checked++;
        if (got !== exp) begin
            miscompares++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic chkLevel(input logic [31:0] got, input logic [31:0] exp);
        chk({1'b0, got}, {1'b0, exp});
    endtask
    task automatic tally_and_finish();
        $display("checked=%0d miscompares=%0d", checked, miscompares);
        if (miscompares == 0 && checked > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask
    // one transfer; an idle edge follows so psel is never driven twice at once
    task automatic wr(input logic [11:0] a, input logic [31:0] d, input logic w = 1'b1);
        int n;
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= w;
        paddr   <= a;
        pwdata  <= d;
        @(posedge sys_clk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge sys_clk);
            n++;
        end while (pready !== 1'b1 && n < 50);
        if (n >= 50) begin
            miscompares++;
            tally_and_finish();
        end else begin
            psel    <= 1'b0;
            penable <= 1'b0;
            @(posedge sys_clk);
        end
    endtask
    task automatic rd(input logic [11:0] a, input logic [32:0] exp);
        readNotes.push_back(exp);
        wr(a, 32'h0, 1'b0);
    endtask
    // high cycles of one pin over a window, after letting buffers settle
    task automatic meas(input logic ch, input int settle, input int n, output int h);
        repeat (settle) @(posedge sys_clk);
        h = 0;
        repeat (n) begin
            @(posedge sys_clk);
            h += ((ch ? pinB : pinA) === 1'b1);
        end
    endtask
    // read results are matched against the oldest note
    always @(posedge sys_clk) begin
        if (psel && penable && !pwrite && pready === 1'b1) begin
            if (readNotes.size() == 0) miscompares++;
            else chk({pslverr, prdata}, readNotes.pop_front());
        end
    end
    initial begin
        #4000000;
        miscompares++;
        tally_and_finish();
    end
    // ****
    // main sequence
    // ****
    initial begin
        seed = 50573;
        {miscompares, checked} = '0;
        {sys_rst, psel, penable, pwrite, extTickPin, dirA, dirB} = 7'h40;
        paddr = 12'h000;
        pwdata = 32'h0;
        repeat (8) @(posedge sys_clk);
        chkLevel(32'({pready, pslverr, irq, compareEnA, compareEnB, compareOutA, compareOutB}),
            0);
        sys_rst <= 1'b0;
        {dirA, dirB} <= 2'h3;
        rd(`TW_ADDR_CTRLA, 33'h0);
        rd(12'h0A0, 33'h100000000);
        wr(`TW_ADDR_CTRLA, 32'hFF);
        rd(`TW_ADDR_CTRLA, 33'h0F3);
        // toggle mode connects only where the mode allows it
        for (int m = 0; m < 16; m++) begin
            wr(`TW_ADDR_CTRLA, 32'h50 | (m & 3));
            wr(`TW_ADDR_CTRLB, (m >> 2) << 3);
            repeat (3) @(posedge sys_clk);
            chkLevel(compareEnA, m inside {0, 4, 9, 11, 12, 14, 15});
            chkLevel(compareEnB, m inside {0, 4, 12});
        end
        wr(`TW_ADDR_CTRLA, 32'h0);
        for (int s = 6; s < 8; s++) begin
            wr(`TW_ADDR_CTRLB, s);
            wr(`TW_ADDR_CNT, 32'h0);
            repeat (8) begin
                repeat (8) @(posedge sys_clk);
                extTickPin <= ~extTickPin;
            end
            repeat (8) @(posedge sys_clk);
            wr(`TW_ADDR_CTRLB, 32'h0);
            rd(`TW_ADDR_CNT, 33'h4);
        end
        // divide by 8: sixteen ticks fit before the stop write lands
        wr(`TW_ADDR_CNT, 32'h0);
        wr(`TW_ADDR_CTRLB, 32'h2);
        repeat (128) @(posedge sys_clk);
        wr(`TW_ADDR_CTRLB, 32'h0);
        rd(`TW_ADDR_CNT, 33'h10);
        // clear on match, toggling A, then the match interrupt
        c1 = 16'h3 + 16'($random(seed) & 15);
        wr(`TW_ADDR_CNT, 32'h0);
        wr(`TW_ADDR_CMPA, {16'h0, c1});
        wr(`TW_ADDR_CMPB, 32'hFFFF);
        wr(`TW_ADDR_CTRLA, 32'h40);
        wr(`TW_ADDR_CTRLB, 32'h09);
        meas(1'b0, 50, 8 * (c1 + 1), h1);
        chkLevel(h1, 4 * (c1 + 1));
        chkLevel(irq, 0);
        wr(`TW_ADDR_MASK, 32'h2);
        repeat (4) @(posedge sys_clk);
        chkLevel(irq, 1);
        wr(`TW_ADDR_CTRLB, 32'h08);
        rd(`TW_ADDR_STAT, 33'h2);
        rd(`TW_ADDR_STAT, 33'h0);
        chkLevel(irq, 0);
        // fast PWM 8-bit on A: duty, inversion, compare at TOP
        c1 = 16'h10 + 16'($random(seed) & 63);
        wr(`TW_ADDR_CNT, 32'h0);
        wr(`TW_ADDR_CMPA, {16'h0, c1});
        wr(`TW_ADDR_CTRLA, 32'h81);
        wr(`TW_ADDR_CTRLB, 32'h09);
        meas(1'b0, 300, 256, h1);
        wr(`TW_ADDR_CMPA, {16'h0, c1 + 16'h20});
        meas(1'b0, 300, 256, h2);
        chkLevel(h2 - h1, 32'h20);
        wr(`TW_ADDR_CTRLA, 32'hC1);
        meas(1'b0, 300, 256, h1);
        chkLevel(h1, 256 - h2);
        wr(`TW_ADDR_CMPA, 32'hFF);
        meas(1'b0, 300, 256, h1);
        chkLevel(h1, 0);
        wr(`TW_ADDR_CTRLA, 32'h81);
        meas(1'b0, 300, 256, h1);
        chkLevel(h1, 256);
        // phase correct 8-bit on B: slope-symmetric duty
        c1 = 16'h10 + 16'($random(seed) & 63);
        wr(`TW_ADDR_CMPB, {16'h0, c1});
        wr(`TW_ADDR_CTRLA, 32'h21);
        wr(`TW_ADDR_CTRLB, 32'h01);
        meas(1'b1, 1100, 510, h1);
        wr(`TW_ADDR_CMPB, {16'h0, c1 + 16'h20});
        meas(1'b1, 1100, 510, h2);
        chkLevel(h2 - h1, 32'h40);
        tally_and_finish();
    end
endmodule
`default_nettype wire

/* File: verif/tw_pin_model.sv */
`default_nettype none
// ****
// port pin beside one compare output
// ****
module tw_pin_model (
    // from the timer
    input  wire logic compareOut,
    input  wire logic compareEn,
    // port side
    input  wire logic dirOut,
    input  wire logic portData,
    // the pin
    output logic      pinLevel
);
    timeunit 1ns;
    timeprecision 1ps;
    // an undriven pin goes to its pull-up, so a stale level never shows
    assign pinLevel = !dirOut ? 1'b1 : (compareEn ? compareOut : portData);
endmodule
`default_nettype wire
